// *** hdl/timer_clock_reset_watchdog_ctrl.sv ***
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module timer_clock_reset_watchdog_ctrl
  import clk_wdt_pkg::*;
#(
  parameter int HOLD_CYCLES = POWER_ON_HOLD_CYCLES
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [8:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_TICK_INTERNAL,
  input wire logic I_TICK_LOW_POWER,
  input wire logic I_TICK_CRYSTAL,
  input wire logic I_TICK_CLOCK_INPUT_PIN,
  input wire logic I_USB_PACKET,
  input wire logic I_USB_TOO_FAST,
  input wire logic I_INTERRUPT_PENDING,
  input wire logic I_GLOBAL_INTERRUPT_STATUS_BIT,
  output logic [7:0] O_RDATA,
  output logic O_CAPTURE_TIMER_CLOCK,
  output logic O_INTERVAL_TIMER_CLOCK,
  output logic O_CLOCK_OUTPUT_PIN,
  output logic O_PROCESSOR_CLOCK,
  output logic O_INTERVAL_IRQ,
  output logic O_SLEEP_IRQ,
  output logic O_WATCHDOG_RESET_EVENT,
  output logic O_CPU_RUN,
  output logic O_OSC_STOP,
  output logic O_TRIM_COARSE_UP,
  output logic O_TRIM_COARSE_DOWN,
  output logic O_TRIM_FINE_UP,
  output logic O_TRIM_FINE_DOWN
);

  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP, ST_WAKE} cpu_state_e;

  // tick inputs come from foreign oscillators, so each passes two flops
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] sync_c;
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
      sync_c <= 5'h00;
    end else begin
      sync_a <= {I_USB_PACKET, I_TICK_CLOCK_INPUT_PIN, I_TICK_CRYSTAL, I_TICK_LOW_POWER, I_TICK_INTERNAL};
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end
  // rising-edge pulses of each source
  logic [4:0] edge_pulse;
  assign edge_pulse = sync_b & ~sync_c;

  logic [7:0] timer_clock_config;
  logic [7:0] clock_pin_output_config;
  logic [7:0] usb_oscillator_lock_config;
  logic [7:0] oscillator_control_zero;
  logic [7:0] clock_cpu_config;
  logic [11:0] interval_reload_value;
  logic watchdog_reset_flag;
  logic power_on_reset_flag;
  logic sleep_bit;
  logic halt_bit;
  logic watchdog_enable;
  logic [2:0] watchdog_counter;
  logic sleep_overflow;
  logic wake_done;
  cpu_state_e cpu_state;

  logic wr_wdt;
  assign wr_wdt = I_WR && (I_ADDR == ADDR_WATCHDOG_CLEAR_REGISTER);

  // external source: crystal when enabled, else plain pin
  logic ext_tick;
  assign ext_tick = clock_pin_output_config[CRYSTAL_ENABLE_BIT] ? edge_pulse[2] : edge_pulse[3];

  function automatic logic pick(input logic [1:0] sel, input logic [4:0] e, input logic ext, input logic fourth);
    unique case (sel)
      SRC_INTERNAL: pick = e[0];
      SRC_EXTERNAL: pick = ext;
      SRC_LOW_POWER: pick = e[1];
      SRC_FOURTH: pick = fourth;
    endcase
  endfunction

  // capture clock: divided source; divider runs on source ticks
  logic cap_src;
  logic [2:0] cap_cnt;
  logic cap_tick;
  logic [2:0] cap_half;
  assign cap_src = pick(timer_clock_config[5:4], edge_pulse, ext_tick, 1'b0);
  assign cap_half = {1'b0, timer_clock_config[7:6]}; // half period 1..4 gives /2,/4,/6,/8
  // the counter only toggles at its terminal count, so a config change never shortens a phase below one tick
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cap_cnt <= 3'h0;
      O_CAPTURE_TIMER_CLOCK <= 1'b0;
    end else if (cap_src) begin
      if (cap_cnt >= cap_half) begin
        cap_cnt <= 3'h0;
        O_CAPTURE_TIMER_CLOCK <= ~O_CAPTURE_TIMER_CLOCK;
      end else begin
        cap_cnt <= cap_cnt + 3'h1;
      end
    end
  end
  assign cap_tick = cap_src && (cap_cnt >= cap_half) && !O_CAPTURE_TIMER_CLOCK;

  // interval clock: prescale 1..4 on the selected source
  logic it_src;
  logic [1:0] it_cnt;
  logic it_tick;
  assign it_src = pick(timer_clock_config[1:0], edge_pulse, ext_tick, cap_tick);
  assign it_tick = it_src && (it_cnt >= timer_clock_config[3:2]);
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      it_cnt <= 2'h0;
      O_INTERVAL_TIMER_CLOCK <= 1'b0;
    end else begin
      if (it_src) begin
        it_cnt <= it_tick ? 2'h0 : it_cnt + 2'h1;
      end
      O_INTERVAL_TIMER_CLOCK <= it_tick;
    end
  end

  // interval down counter
  logic [11:0] interval_down_counter;
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      interval_down_counter <= 12'h000;
      O_INTERVAL_IRQ <= 1'b0;
    end else begin
      O_INTERVAL_IRQ <= 1'b0;
      if (it_tick) begin
        if (interval_down_counter == 12'h000) begin
          interval_down_counter <= interval_reload_value;
          O_INTERVAL_IRQ <= 1'b1;
        end else begin
          interval_down_counter <= interval_down_counter - 12'h001;
        end
      end
    end
  end

  // processor clock: internal or external source over 2^n
  logic cpu_src;
  logic [6:0] cpu_cnt;
  logic [6:0] cpu_limit;
  logic cpu_ext_sel;
  assign cpu_ext_sel = clock_cpu_config[CPU_SELECT_BIT] && (cpu_state != ST_SLEEP) && (cpu_state != ST_WAKE);
  assign cpu_src = cpu_ext_sel ? ext_tick : edge_pulse[0];
  always_comb begin
    unique case (oscillator_control_zero[2:0])
      3'h0: cpu_limit = 7'h07;
      3'h1: cpu_limit = 7'h03;
      3'h2: cpu_limit = 7'h01;
      3'h3: cpu_limit = 7'h00;
      3'h4: cpu_limit = 7'h0F;
      3'h5: cpu_limit = 7'h1F;
      3'h6: cpu_limit = 7'h7F;
      3'h7: cpu_limit = 7'h7F;
    endcase
  end
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cpu_cnt <= 7'h00;
      O_PROCESSOR_CLOCK <= 1'b0;
    end else begin
      O_PROCESSOR_CLOCK <= 1'b0;
      if (cpu_src && !O_OSC_STOP) begin
        if (cpu_cnt >= cpu_limit) begin
          cpu_cnt <= 7'h00;
          O_PROCESSOR_CLOCK <= 1'b1;
        end else begin
          cpu_cnt <= cpu_cnt + 7'h01;
        end
      end
    end
  end

  // clock output pin source
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_CLOCK_OUTPUT_PIN <= 1'b0;
    end else begin
      O_CLOCK_OUTPUT_PIN <= pick(clock_pin_output_config[1:0], edge_pulse, ext_tick, O_PROCESSOR_CLOCK);
    end
  end

  // usb oscillator lock: compares packets against internal tick count
  logic [15:0] trim_cnt;
  logic lock_active;
  logic [15:0] trim_target;
  assign trim_target = 16'h3000;
  assign lock_active = !usb_oscillator_lock_config[LOCK_DISABLE_BIT] && !clock_cpu_config[USB_SELECT_BIT];
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      trim_cnt <= 16'h0000;
      O_TRIM_COARSE_UP <= 1'b0;
      O_TRIM_COARSE_DOWN <= 1'b0;
      O_TRIM_FINE_UP <= 1'b0;
      O_TRIM_FINE_DOWN <= 1'b0;
    end else begin
      O_TRIM_COARSE_UP <= 1'b0;
      O_TRIM_COARSE_DOWN <= 1'b0;
      O_TRIM_FINE_UP <= 1'b0;
      O_TRIM_FINE_DOWN <= 1'b0;
      if (edge_pulse[4]) begin
        trim_cnt <= 16'h0000;
        if (lock_active) begin
          if (!usb_oscillator_lock_config[FINE_ONLY_BIT] && I_USB_TOO_FAST && trim_cnt > 16'h3300) begin
            O_TRIM_COARSE_DOWN <= 1'b1;
          end else if (!usb_oscillator_lock_config[FINE_ONLY_BIT] && !I_USB_TOO_FAST && trim_cnt < 16'h2D00) begin
            O_TRIM_COARSE_UP <= 1'b1;
          end else if (trim_cnt > trim_target) begin
            O_TRIM_FINE_DOWN <= 1'b1;
          end else if (trim_cnt < trim_target) begin
            O_TRIM_FINE_UP <= 1'b1;
          end
        end
      end else if (edge_pulse[0] && trim_cnt != 16'hFFFF) begin
        trim_cnt <= trim_cnt + 16'h0001;
      end
    end
  end

  // sleep timer on low-power ticks
  logic [14:0] sleep_cnt;
  logic [14:0] sleep_limit;
  always_comb begin
    unique case (oscillator_control_zero[4:3])
      2'h0: sleep_limit = SLEEP_DIV_512;
      2'h1: sleep_limit = SLEEP_DIV_64;
      2'h2: sleep_limit = SLEEP_DIV_8;
      2'h3: sleep_limit = SLEEP_DIV_1;
    endcase
  end
  assign sleep_overflow = edge_pulse[1] && (sleep_cnt >= sleep_limit);
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      sleep_cnt <= 15'h0000;
      O_SLEEP_IRQ <= 1'b0;
    end else begin
      O_SLEEP_IRQ <= sleep_overflow;
      if (wr_wdt && I_WDATA == WATCHDOG_CLEAR_KEY) begin
        sleep_cnt <= 15'h0000;
      end else if (edge_pulse[1]) begin
        sleep_cnt <= sleep_overflow ? 15'h0000 : sleep_cnt + 15'h0001;
      end
    end
  end

  // watchdog counter; the reset pulse goes to the system reset controller
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      watchdog_counter <= 3'h0;
      O_WATCHDOG_RESET_EVENT <= 1'b0;
    end else begin
      O_WATCHDOG_RESET_EVENT <= 1'b0;
      if (wr_wdt) begin
        watchdog_counter <= 3'h0;
      end else if (sleep_overflow && watchdog_enable && !power_on_reset_flag) begin
        if (watchdog_counter + 3'h1 >= WATCHDOG_LIMIT) begin
          watchdog_counter <= 3'h0;
          O_WATCHDOG_RESET_EVENT <= 1'b1;
        end else begin
          watchdog_counter <= watchdog_counter + 3'h1;
        end
      end
    end
  end

  // cpu sequencing
  logic [$clog2(HOLD_CYCLES+1)-1:0] hold_cnt;
  logic [1:0] wake_cnt;
  assign wake_done = edge_pulse[1] && (wake_cnt + 2'h1 >= WAKE_RECOVERY_TICKS);
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      cpu_state <= ST_HOLD;
      hold_cnt <= '0;
      wake_cnt <= 2'h0;
      O_CPU_RUN <= 1'b0;
      O_OSC_STOP <= 1'b0;
    end else begin
      unique case (cpu_state)
        ST_HOLD: begin
          if (hold_cnt == ($clog2(HOLD_CYCLES+1))'(HOLD_CYCLES - 1)) begin
            cpu_state <= ST_RUN;
            O_CPU_RUN <= !halt_bit;
          end else begin
            hold_cnt <= hold_cnt + 1'b1;
          end
        end
        ST_RUN: begin
          if (halt_bit) begin
            O_CPU_RUN <= 1'b0;
          end else if (sleep_bit) begin
            cpu_state <= ST_SLEEP;
            O_CPU_RUN <= 1'b0;
            O_OSC_STOP <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (I_INTERRUPT_PENDING) begin
            cpu_state <= ST_WAKE;
            O_OSC_STOP <= 1'b0;
            wake_cnt <= 2'h0;
          end
        end
        ST_WAKE: begin
          if (wake_done) begin
            cpu_state <= ST_RUN;
            O_CPU_RUN <= !halt_bit;
          end else if (edge_pulse[1]) begin
            wake_cnt <= wake_cnt + 2'h1;
          end
        end
      endcase
    end
  end

  // register writes; reset is a power-on or watchdog reset fed back to I_RESET
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      timer_clock_config <= TIMER_CLOCK_CONFIG_RESET;
      clock_pin_output_config <= 8'h00;
      usb_oscillator_lock_config <= 8'h00;
      oscillator_control_zero <= 8'h00;
      clock_cpu_config <= 8'h00;
      interval_reload_value <= 12'h000;
    end else if (I_WR) begin
      unique case (I_ADDR)
        ADDR_TIMER_CLOCK_CONFIG: timer_clock_config <= I_WDATA;
        ADDR_CLOCK_PIN_OUTPUT_CONFIG: clock_pin_output_config <= I_WDATA & 8'h07;
        ADDR_USB_OSCILLATOR_LOCK_CONFIG: usb_oscillator_lock_config <= I_WDATA & 8'h03;
        ADDR_OSCILLATOR_CONTROL_ZERO: oscillator_control_zero <= I_WDATA & 8'h3F;
        ADDR_CLOCK_CPU_CONFIG: clock_cpu_config <= I_WDATA & 8'h61;
        ADDR_RELOAD_LOW: interval_reload_value[7:0] <= I_WDATA;
        ADDR_RELOAD_HIGH: interval_reload_value[11:8] <= I_WDATA[3:0];
        default: ;
      endcase
    end
  end

  // status and control; software can only clear the flags, and reset reloads them (watchdog flag cleared, power-on flag set)
  logic scr_wr;
  assign scr_wr = I_WR && (I_ADDR == ADDR_SYSTEM_STATUS_CONTROL);
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      power_on_reset_flag <= SYSTEM_STATUS_RESET[POWER_ON_FLAG_BIT];
      watchdog_reset_flag <= SYSTEM_STATUS_RESET[WATCHDOG_FLAG_BIT];
      sleep_bit <= 1'b0;
      halt_bit <= 1'b0;
    end else begin
      if (scr_wr && !I_WDATA[POWER_ON_FLAG_BIT]) begin
        power_on_reset_flag <= 1'b0;
      end
      if (O_WATCHDOG_RESET_EVENT) begin
        watchdog_reset_flag <= 1'b1;
      end else if (scr_wr && !I_WDATA[WATCHDOG_FLAG_BIT]) begin
        watchdog_reset_flag <= 1'b0;
      end
      if (scr_wr) begin
        sleep_bit <= I_WDATA[SLEEP_BIT];
        halt_bit <= halt_bit | I_WDATA[HALT_BIT];
      end else if (cpu_state == ST_WAKE && wake_done) begin
        sleep_bit <= 1'b0;
      end
    end
  end

  // watchdog enable shares I_RESET with the other registers: any reset clears it, a write with the power-on flag bit low sets it
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      watchdog_enable <= 1'b0;
    end else if (scr_wr && !I_WDATA[POWER_ON_FLAG_BIT]) begin
      watchdog_enable <= 1'b1;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      unique case (I_ADDR)
        ADDR_TIMER_CLOCK_CONFIG: O_RDATA <= timer_clock_config;
        ADDR_CLOCK_PIN_OUTPUT_CONFIG: O_RDATA <= clock_pin_output_config;
        ADDR_USB_OSCILLATOR_LOCK_CONFIG: O_RDATA <= usb_oscillator_lock_config;
        ADDR_OSCILLATOR_CONTROL_ZERO: O_RDATA <= oscillator_control_zero;
        ADDR_CLOCK_CPU_CONFIG: O_RDATA <= clock_cpu_config;
        ADDR_RELOAD_LOW: O_RDATA <= interval_reload_value[7:0];
        ADDR_RELOAD_HIGH: O_RDATA <= {4'h0, interval_reload_value[11:8]};
        ADDR_SYSTEM_STATUS_CONTROL: O_RDATA <= {I_GLOBAL_INTERRUPT_STATUS_BIT, 1'b0, watchdog_reset_flag,
          power_on_reset_flag, sleep_bit, 2'h0, halt_bit};
        default: O_RDATA <= 8'h00;
      endcase
    end else begin
      O_RDATA <= 8'h00;
    end
  end

endmodule // timer_clock_reset_watchdog_ctrl

// *** hdl/clk_wdt_pkg.sv ***
package clk_wdt_pkg;
  // register offsets
  localparam logic [8:0] ADDR_TIMER_CLOCK_CONFIG = 9'h031;
  localparam logic [8:0] ADDR_CLOCK_PIN_OUTPUT_CONFIG = 9'h032;
  localparam logic [8:0] ADDR_USB_OSCILLATOR_LOCK_CONFIG = 9'h039;
  localparam logic [8:0] ADDR_SYSTEM_STATUS_CONTROL = 9'h0FF;
  localparam logic [8:0] ADDR_WATCHDOG_CLEAR_REGISTER = 9'h0E3;
  localparam logic [8:0] ADDR_OSCILLATOR_CONTROL_ZERO = 9'h1E0;
  localparam logic [8:0] ADDR_RELOAD_LOW = 9'h024;
  localparam logic [8:0] ADDR_RELOAD_HIGH = 9'h025;
  localparam logic [8:0] ADDR_CLOCK_CPU_CONFIG = 9'h030;
  // reset values and the watchdog clear key
  localparam logic [7:0] TIMER_CLOCK_CONFIG_RESET = 8'h0C;
  localparam logic [7:0] SYSTEM_STATUS_RESET = 8'h10;
  localparam logic [7:0] WATCHDOG_CLEAR_KEY = 8'h38;
  // field positions
  localparam int LOCK_DISABLE_BIT = 0;
  localparam int FINE_ONLY_BIT = 1;
  localparam int CRYSTAL_ENABLE_BIT = 2;
  localparam int WATCHDOG_FLAG_BIT = 5;
  localparam int POWER_ON_FLAG_BIT = 4;
  localparam int SLEEP_BIT = 3;
  localparam int HALT_BIT = 0;
  localparam int CPU_SELECT_BIT = 0;
  localparam int USB_SELECT_BIT = 5;
  // sources
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  localparam logic [1:0] SRC_EXTERNAL = 2'h1;
  localparam logic [1:0] SRC_LOW_POWER = 2'h2;
  localparam logic [1:0] SRC_FOURTH = 2'h3;
  // counts
  localparam logic [2:0] WATCHDOG_LIMIT = 3'h3;
  localparam logic [1:0] WAKE_RECOVERY_TICKS = 2'h3;
  localparam logic [2:0] CPU_RESET_DIVIDE = 3'h7;
  localparam real CLOCK_MHZ = 20.0;
  localparam real POWER_ON_HOLD_MS = 20.0;
  localparam int POWER_ON_HOLD_CYCLES = int'(POWER_ON_HOLD_MS * 1000.0 * CLOCK_MHZ);
  // sleep timer prescale in low-power ticks: 32768 / 512, 64, 8, 1
  localparam logic [14:0] SLEEP_DIV_512 = 15'h003F;
  localparam logic [14:0] SLEEP_DIV_64 = 15'h01FF;
  localparam logic [14:0] SLEEP_DIV_8 = 15'h0FFF;
  localparam logic [14:0] SLEEP_DIV_1 = 15'h7FFF;
endpackage

// *** verif/tick_source_model.sv ***
`timescale 1ns/1ps
module tick_source_model (
  output logic o_internal,
  output logic o_low_power,
  output logic o_crystal,
  output logic o_pin
);
  // edges fall between rising bench clock edges, so each one is seen on a known cycle
  initial begin
    o_internal = 1'b0;
    o_low_power = 1'b0;
    o_crystal = 1'b0;
    o_pin = 1'b0;
  end
  always #200 o_internal = ~o_internal;
  // free-running low-power source feeds the sleep timer
  always #400 o_low_power = ~o_low_power;
  always #300 o_crystal = ~o_crystal;
  always #500 o_pin = ~o_pin;
endmodule // tick_source_model

// *** verif/timer_clock_reset_watchdog_ctrl_monitor.sv ***
`timescale 1ns/1ps
module timer_clock_reset_watchdog_ctrl_monitor
  import clk_wdt_pkg::*;
#(
  parameter int HOLD_CYCLES = 10
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [8:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic O_INTERVAL_TIMER_CLOCK,
  input wire logic O_INTERVAL_IRQ,
  input wire logic O_SLEEP_IRQ,
  input wire logic O_WATCHDOG_RESET_EVENT,
  input wire logic O_CPU_RUN,
  input wire logic O_OSC_STOP,
  input wire logic O_TRIM_COARSE_UP,
  input wire logic O_TRIM_COARSE_DOWN,
  input wire logic O_TRIM_FINE_UP,
  input wire logic O_TRIM_FINE_DOWN
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  logic wdt_on;
  logic halted;
  logic lock_off;
  logic fine_only;
  logic any_trim;
  int unsigned since_rst;
  assign any_trim = O_TRIM_COARSE_UP | O_TRIM_COARSE_DOWN | O_TRIM_FINE_UP | O_TRIM_FINE_DOWN;
  // the flag can only be cleared, so enable stays until the next reset
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      wdt_on <= 1'b0;
      halted <= 1'b0;
    end else if (I_WR && I_ADDR == ADDR_SYSTEM_STATUS_CONTROL) begin
      if (!I_WDATA[POWER_ON_FLAG_BIT]) wdt_on <= 1'b1;
      if (I_WDATA[HALT_BIT]) halted <= 1'b1;
    end
  end
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) begin
      lock_off <= 1'b0;
      fine_only <= 1'b0;
    end else if (I_WR && I_ADDR == ADDR_USB_OSCILLATOR_LOCK_CONFIG) begin
      lock_off <= I_WDATA[LOCK_DISABLE_BIT];
      fine_only <= I_WDATA[FINE_ONLY_BIT];
    end
  end
  always_ff @(posedge I_CLK or posedge I_RESET) begin
    if (I_RESET) since_rst <= 0;
    else if (since_rst < HOLD_CYCLES) since_rst <= since_rst + 1;
  end
  irq_after_tick_a: assert property (O_INTERVAL_IRQ |-> O_INTERVAL_TIMER_CLOCK)
    else $error("interval irq without a reload tick");
  irq_single_a: assert property (O_INTERVAL_IRQ |=> !O_INTERVAL_IRQ)
    else $error("interval irq longer than one cycle");
  wdt_gated_a: assert property (!wdt_on |-> !O_WATCHDOG_RESET_EVENT)
    else $error("watchdog reset while power-on flag set");
  halt_stops_a: assert property ($past(halted, 2) |-> !O_CPU_RUN)
    else $error("cpu runs after halt");
  sleep_stops_a: assert property (O_OSC_STOP && $past(O_OSC_STOP, 2) |-> !O_CPU_RUN)
    else $error("cpu runs while asleep");
  power_hold_a: assert property (since_rst < HOLD_CYCLES |-> !O_CPU_RUN)
    else $error("cpu released too early");
  trim_locked_a: assert property (lock_off && $past(lock_off, 4) |-> !any_trim)
    else $error("trim while lock disabled");
  coarse_skip_a: assert property (fine_only && $past(fine_only, 4) |-> !(O_TRIM_COARSE_UP || O_TRIM_COARSE_DOWN))
    else $error("coarse trim in fine-only mode");
  cover property (O_INTERVAL_IRQ);
  cover property (O_SLEEP_IRQ);
  cover property (wdt_on && O_WATCHDOG_RESET_EVENT);
  cover property ($fell(O_OSC_STOP));
endmodule // timer_clock_reset_watchdog_ctrl_monitor

// *** verif/timer_clock_reset_watchdog_ctrl_tb.sv ***
`timescale 1ns/1ps
module timer_clock_reset_watchdog_ctrl_tb;
  import clk_wdt_pkg::*;
  localparam int HOLD = 10;
  logic clk;
  logic reset = 1'b1, wr = 1'b0, rd = 1'b0, usb_pkt = 1'b0, too_fast = 1'b0, int_pend = 1'b0, global_interrupt_status_bit = 1'b0;
  logic rd_seen = 1'b0, wd_seen = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00, rdata, r, exp_q[$];
  logic cap_clk, itmr_clk, clk_pin, cpu_clk, itmr_irq, slp_irq, wd_evt, cpu_run, osc_stop, cu, cd, fu, fd;
  logic t_int, t_lp, t_xtal, t_pin;
  logic [31:0] seed = 32'hA95FACBC;
  int err_count = 0, samples_checked = 0, cycles = 0, c, n, e;
  timer_clock_reset_watchdog_ctrl #(.HOLD_CYCLES(HOLD)) i_timer_clock_reset_watchdog_ctrl (
    .I_CLK(clk), .I_RESET(reset), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .I_TICK_INTERNAL(t_int), .I_TICK_LOW_POWER(t_lp), .I_TICK_CRYSTAL(t_xtal), .I_TICK_CLOCK_INPUT_PIN(t_pin),
    .I_USB_PACKET(usb_pkt), .I_USB_TOO_FAST(too_fast), .I_INTERRUPT_PENDING(int_pend),
    .I_GLOBAL_INTERRUPT_STATUS_BIT(global_interrupt_status_bit), .O_RDATA(rdata), .O_CAPTURE_TIMER_CLOCK(cap_clk),
    .O_INTERVAL_TIMER_CLOCK(itmr_clk), .O_CLOCK_OUTPUT_PIN(clk_pin), .O_PROCESSOR_CLOCK(cpu_clk),
    .O_INTERVAL_IRQ(itmr_irq), .O_SLEEP_IRQ(slp_irq), .O_WATCHDOG_RESET_EVENT(wd_evt), .O_CPU_RUN(cpu_run),
    .O_OSC_STOP(osc_stop), .O_TRIM_COARSE_UP(cu), .O_TRIM_COARSE_DOWN(cd), .O_TRIM_FINE_UP(fu),
    .O_TRIM_FINE_DOWN(fd));
  tick_source_model i_tick_source_model (.o_internal(t_int), .o_low_power(t_lp), .o_crystal(t_xtal), .o_pin(t_pin));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // source periods in bench cycles; 3 is the capture clock at its reset divide of two
  function automatic int src_p(input int s, input bit x);
    case (s)
      0: return 8;
      1: return x ? 12 : 20;
      default: return 16;
    endcase
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: return cap_clk;
      1: return itmr_clk;
      2: return clk_pin;
      3: return itmr_irq;
      default: return slp_irq;
    endcase
  endfunction
  task automatic stop_test();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check_rd(input logic [7:0] x);
    samples_checked++;
    if (rdata !== x) begin
      err_count++;
      $display("CHECK FAILED %0t read %h want %h", $time, rdata, x);
    end
  endtask
  task automatic check_bit(input logic g, input logic x);
    samples_checked++;
    if (g !== x) begin
      err_count++;
      $display("CHECK FAILED %0t level %b want %b", $time, g, x);
    end
  endtask
  task automatic check_val(input int g, input int lo, input int hi);
    samples_checked++;
    if (g < lo || g > hi) begin
      err_count++;
      $display("CHECK FAILED %0t count %0d want %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // a spare cycle after each strobe keeps one assignment per signal per time step
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [8:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask
  // spacing of the second and third rising edge; zero when fewer than two come
  task automatic period(input int w, input int lim, output int cyc);
    int rises;
    logic prev;
    logic cur;
    rises = 0;
    cyc = 0;
    prev = 1'b1;
    for (int k = 0; k < lim && rises < 3; k++) begin
      @(posedge clk);
      cur = pick(w);
      if (cur && !prev) rises++;
      if (rises == 2) cyc++;
      prev = cur;
    end
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      stop_test();
    end
  end
  always @(posedge clk) begin
    if (rd_seen) check_rd(exp_q.pop_front());
    if (wd_evt) wd_seen <= 1'b1;
    rd_seen <= rd;
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_reg(ADDR_TIMER_CLOCK_CONFIG, TIMER_CLOCK_CONFIG_RESET);
    rd_reg(ADDR_CLOCK_PIN_OUTPUT_CONFIG, 8'h00);
    rd_reg(ADDR_USB_OSCILLATOR_LOCK_CONFIG, 8'h00);
    rd_reg(ADDR_SYSTEM_STATUS_CONTROL, SYSTEM_STATUS_RESET);
    rd_reg(9'h100, 8'h00);
    repeat (HOLD) @(posedge clk);
    check_bit(cpu_run, 1'b1);
    seed = xs(seed);
    wr_reg(ADDR_TIMER_CLOCK_CONFIG, seed[7:0]);
    rd_reg(ADDR_TIMER_CLOCK_CONFIG, seed[7:0]);
    wr_reg(ADDR_CLOCK_PIN_OUTPUT_CONFIG, 8'h04);
    for (int s = 0; s < 3; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr_reg(ADDR_TIMER_CLOCK_CONFIG, {d[1:0], s[1:0], 4'h0});
        period(0, 2000, c);
        e = (d + 1) * 2 * src_p(s, 1);
        check_val(c, e, e);
      end
    end
    wr_reg(ADDR_TIMER_CLOCK_CONFIG, 8'h30);
    period(0, 400, c);
    check_val(c, 0, 0);
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr_reg(ADDR_TIMER_CLOCK_CONFIG, {4'h0, d[1:0], s[1:0]});
        period(1, 2000, c);
        e = (d + 1) * src_p(s, 1);
        check_val(c, e, e);
      end
    end
    wr_reg(ADDR_CLOCK_PIN_OUTPUT_CONFIG, 8'h00);
    wr_reg(ADDR_TIMER_CLOCK_CONFIG, 8'h01);
    period(1, 2000, c);
    check_val(c, 20, 20);
    for (int k = 0; k < 4; k++) begin
      wr_reg(ADDR_CLOCK_PIN_OUTPUT_CONFIG, k[7:0]);
      period(2, 2000, c);
      e = (k == 3) ? 64 : src_p(k, 0);
      check_val(c, e, e);
    end
    seed = xs(seed);
    r = {2'h0, seed[5:0]} | 8'h01;
    wr_reg(ADDR_TIMER_CLOCK_CONFIG, 8'h00);
    wr_reg(ADDR_RELOAD_HIGH, 8'h01);
    wr_reg(ADDR_RELOAD_LOW, r);
    rd_reg(ADDR_RELOAD_LOW, r);
    rd_reg(ADDR_RELOAD_HIGH, 8'h01);
    period(3, 8000, c);
    e = (256 + r + 1) * 8;
    check_val(c, e, e);
    for (int i = 0; i < 12; i++) begin
      if (i % 4 == 0) wr_reg(ADDR_USB_OSCILLATOR_LOCK_CONFIG, 8'((i / 4 + 1) % 3));
      usb_pkt <= ~usb_pkt;
      seed = xs(seed);
      too_fast <= seed[0];
      repeat (40) @(posedge clk);
    end
    rd_reg(ADDR_USB_OSCILLATOR_LOCK_CONFIG, 8'h00);
    wr_reg(ADDR_OSCILLATOR_CONTROL_ZERO, 8'h00);
    period(4, 5000, c);
    check_val(c, 1024, 1024);
    wr_reg(ADDR_OSCILLATOR_CONTROL_ZERO, 8'h08);
    period(4, 30000, c);
    check_val(c, 8192, 8192);
    wr_reg(ADDR_OSCILLATOR_CONTROL_ZERO, 8'h00);
    wr_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h18);
    repeat (4) @(posedge clk);
    check_bit(osc_stop, 1'b1);
    check_bit(cpu_run, 1'b0);
    int_pend <= 1'b1;
    n = 0;
    while (cpu_run !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    check_val(n, 32, 80);
    check_bit(osc_stop, 1'b0);
    wr_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h10);
    int_pend <= 1'b0;
    wr_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    rd_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h00);
    wr_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h30);
    global_interrupt_status_bit <= 1'b1;
    rd_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h80);
    for (int i = 0; i < 6; i++) begin
      repeat (700) @(posedge clk);
      wr_reg(ADDR_WATCHDOG_CLEAR_REGISTER, i[0] ? 8'h5A : WATCHDOG_CLEAR_KEY);
    end
    check_bit(wd_seen, 1'b0);
    wr_reg(ADDR_WATCHDOG_CLEAR_REGISTER, WATCHDOG_CLEAR_KEY);
    n = 0;
    while (wd_evt !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    check_val(n, 3040, 3100);
    rd_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'hA0);
    reset <= 1'b1;
    global_interrupt_status_bit <= 1'b0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_reg(ADDR_SYSTEM_STATUS_CONTROL, SYSTEM_STATUS_RESET);
    wr_reg(ADDR_SYSTEM_STATUS_CONTROL, 8'h11);
    repeat (HOLD + 8) @(posedge clk);
    check_bit(cpu_run, 1'b0);
    stop_test();
  end
endmodule // timer_clock_reset_watchdog_ctrl_tb
bind timer_clock_reset_watchdog_ctrl timer_clock_reset_watchdog_ctrl_monitor #(.HOLD_CYCLES(HOLD_CYCLES))
  i_timer_clock_reset_watchdog_ctrl_monitor (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .O_INTERVAL_TIMER_CLOCK(O_INTERVAL_TIMER_CLOCK), .O_INTERVAL_IRQ(O_INTERVAL_IRQ), .O_SLEEP_IRQ(O_SLEEP_IRQ),
  .O_WATCHDOG_RESET_EVENT(O_WATCHDOG_RESET_EVENT), .O_CPU_RUN(O_CPU_RUN), .O_OSC_STOP(O_OSC_STOP),
  .O_TRIM_COARSE_UP(O_TRIM_COARSE_UP), .O_TRIM_COARSE_DOWN(O_TRIM_COARSE_DOWN),
  .O_TRIM_FINE_UP(O_TRIM_FINE_UP), .O_TRIM_FINE_DOWN(O_TRIM_FINE_DOWN));
